//--- shared/sco_map.svh
`ifndef SCO_MAP_SVH
`define SCO_MAP_SVH
// Opcodes written to the command register
`define SCO_OP_STREAM     8'h51
`define SCO_OP_OVERLAY    8'hb1
// Overlay feature codes
`define SCO_DCO_RESTORE   8'hc0
`define SCO_DCO_FREEZE    8'hc1
`define SCO_DCO_IDENTIFY  8'hc2
`define SCO_DCO_SET       8'hc3
// Feature field positions
`define SCO_FEAT_ADD      7
`define SCO_FEAT_DIR      6
`define SCO_FEAT_SEL_HI   2
`define SCO_FEAT_LIM_HI   15
`define SCO_FEAT_LIM_LO   8
// Error and status bits
`define SCO_ERR_ABT       2
`define SCO_STS_ERR       0
`define SCO_STS_DRQ       3
`define SCO_STS_DF        5
`define SCO_STS_RDY       6
`define SCO_STS_BSY       7
`define SCO_STS_RESET     8'h40
// Interrupt status bits
`define SCO_INT_DONE      0
`define SCO_INT_ABORT     1
`define SCO_INT_FREEZE    2
// Register byte offsets
`define SCO_A_FEATURE     8'h00
`define SCO_A_COUNT       8'h04
`define SCO_A_COMMAND     8'h08
`define SCO_A_ERROR       8'h0c
`define SCO_A_STATUS      8'h10
`define SCO_A_COUNT_OUT   8'h14
`define SCO_A_CYL         8'h18
`define SCO_A_INT_STS     8'h1c
`define SCO_A_INT_MASK    8'h20
`define SCO_A_LIM_UNIT    8'h24
`define SCO_A_ELAPSED     8'h28
// Timing: one microsecond at the 4 ns clock
`define SCO_US_NS         1000
`define SCO_CLK_NS        4
`define SCO_US_CYCLES     ((`SCO_US_NS + `SCO_CLK_NS - 1) / `SCO_CLK_NS)
`endif

//--- shared/sco_pkg.sv
package sco_pkg;
    // Command sequencer states
    typedef enum logic [1:0] {
        SCO_IDLE = 2'b00,
        SCO_EXEC = 2'b01,
        SCO_WAIT = 2'b10
    } sco_fsm_t;

    // Whole module state
    typedef struct packed {
        sco_fsm_t         state;
        logic [15:0]      feature;
        logic [15:0]      count;
        logic [7:0]       command;
        logic [7:0]       error;
        logic [7:0]       status;
        logic [7:0]       count_out;
        logic [7:0]       cyl_lo;
        logic [7:0]       cyl_hi;
        logic             intrq;
        logic             irq;
        logic [2:0]       int_sts;
        logic [2:0]       int_mask;
        logic [31:0]      limit_unit;
        logic             freeze;
        logic [7:0]       valid;
        logic [7:0]       dir;
        logic [7:0][39:0] def_limit;
        logic [7:0][15:0] alloc;
        logic [7:0]       prescale;
        logic [31:0]      elapsed;
        logic             sup_meta;
        logic             sup_sync;
        logic [31:0]      rdata;
        logic [39:0]      limit;
        logic             limit_valid;
        logic             identify_req;
        logic             check_req;
        logic             check_set;
    } sco_state_t;
endpackage

//--- verif/sco_chk_model.sv
// Overlay restriction checker: answers each check request after a chosen delay
module sco_chk_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       check_req,
    input  wire logic       violate,
    input  wire logic [7:0] reason,
    input  wire logic [7:0] word,
    input  wire logic [7:0] bit_loc,
    input  wire logic [3:0] delay,
    output logic            check_done,
    output logic            check_violation,
    output logic      [7:0] check_reason,
    output logic      [7:0] check_word,
    output logic      [7:0] check_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt;  // Cycles left until the answer, zero when idle
    logic [7:0] junk; // Moving pattern so stale codes never look valid

    // Answer sequencer; codes are only meaningful in the done cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt        <= 5'h00;
            junk       <= 8'h3c;
            check_done <= 1'b0;
        end else begin
            junk       <= junk + 8'h5b;
            check_done <= (cnt == 5'h01);
            if (check_req) begin
                cnt <= {1'b0, delay} + 5'h01;
            end else if (cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
            end
        end
        check_violation <= (cnt == 5'h01) ? violate : junk[0];
        check_reason    <= (cnt == 5'h01) ? reason : junk;
        check_word      <= (cnt == 5'h01) ? word : ~junk;
        check_bit       <= (cnt == 5'h01) ? bit_loc : junk ^ 8'ha5;
    end
endmodule

//--- verif/tb_top.sv
`include "sco_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [39:0] MIN = 40'h64; // Minimum limit raised above the default of 1
    logic clk = 1'b0, reset = 1'b1, por = 1'b1, rd = 1'b0, wr = 1'b0, sup = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, unit;
    logic req, cset, done, viol, ireq, intrq, irq, lvalid;
    logic [7:0] reason, word, bitl;
    logic [39:0] lim_us;
    logic sv = 1'b0, vio = 1'b0;
    logic [2:0] ssel = 3'h0;
    logic [39:0] s_lim = 40'h0;
    logic [7:0] vr = 8'h0, vw = 8'h0, vb = 8'h0, l = 8'h0;
    logic [3:0] dly = 4'h0;
    logic [2:0] sel;
    logic rd_d = 1'b0;
    logic [31:0] rd_q[$]; // Expected read data, oldest first
    logic [39:0] lim_q[$]; // Expected applied limits
    int failures = 0, check_count = 0, cycles = 0;

    always #2 clk = ~clk;

    sco_cmd #(.MIN_LIMIT_US(MIN)) i_sco_cmd (.clk(clk), .reset(reset), .power_on_reset(por), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .streaming_supported(sup),
        .check_req(req), .check_set(cset), .check_done(done), .check_violation(viol), .check_reason(reason),
        .check_word(word), .check_bit(bitl), .identify_req(ireq), .strm_cmd_valid(sv), .strm_cmd_sel(ssel),
        .strm_cmd_limit(s_lim), .strm_limit_us(lim_us), .strm_limit_valid(lvalid), .intrq(intrq), .irq(irq));
    sco_chk_model i_sco_chk_model (.clk(clk), .reset(reset | por), .check_req(req), .violate(vio),
        .reason(vr), .word(vw), .bit_loc(vb), .delay(dly), .check_done(done), .check_violation(viol),
        .check_reason(reason), .check_word(word), .check_bit(bitl));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Compare tasks, one per kind of result
    task automatic cmp32(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cmp_flag(input string n, input logic e, input logic s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %b seen %b", n, e, s);
        end
    endtask
    // Register bus master: one-cycle strobes, gap cycle between accesses
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // Issue a command, wait for completion, check status, error and interrupt clear
    task automatic cmd(input logic [7:0] op, input logic [15:0] feat, input logic [7:0] st);
        int n;
        wreg(`SCO_A_FEATURE, {16'h0, feat});
        wreg(`SCO_A_COMMAND, {24'h0, op});
        n = 0;
        @(posedge clk);
        while (intrq !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        cmp_flag("intrq_done", 1'b1, intrq);
        rreg(`SCO_A_STATUS, {24'h0, st});
        rreg(`SCO_A_ERROR, st[0] ? 32'h4 : 32'h0);
        cmp_flag("intrq_clear", 1'b0, intrq);
    endtask
    // Later streaming command with limit s_lim on a selector
    task automatic slim(input logic [2:0] s, input logic [39:0] e);
        @(posedge clk);
        sv <= 1'b1;
        ssel <= s;
        lim_q.push_back(e);
        @(posedge clk);
        sv <= 1'b0;
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        cmp_flag("irq", e, irq);
    endtask
    function automatic logic [39:0] exp_lim(input logic [7:0] lb);
        logic [39:0] p;
        p = {32'h0, lb} * {8'h0, unit};
        return (p < MIN) ? MIN : p;
    endfunction

    // Monitor: take the oldest note whenever a result appears
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) cmp32("reg_rdata", rd_q.size() ? rd_q.pop_front() : 32'hx, rdata);
        if (lvalid === 1'b1) cmp32("limit", lim_q.size() ? lim_q.pop_front() : 32'hx, lim_us[31:0]);
        if (lvalid === 1'b1) cmp32("limit_hi", 32'h0, {24'h0, lim_us[39:32]});
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    initial begin
        repeat (19) @(posedge clk);
        por <= 1'b0;
        @(posedge clk);
        reset <= 1'b0;
        void'($urandom(32'h18ec));
        unit = ($urandom % 32'hff) + 32'h1;
        sel = 3'($urandom);
        rreg(`SCO_A_STATUS, 32'h40);
        rreg(8'h30, 32'h0);
        wreg(`SCO_A_LIM_UNIT, unit);
        rreg(`SCO_A_LIM_UNIT, unit);
        cmd(`SCO_OP_STREAM, {8'h05, 5'h10, sel}, 8'h41);
        sup <= 1'b1;
        repeat (4) @(posedge clk);
        cmd(`SCO_OP_STREAM, {8'h05, 5'h00, sel}, 8'h41);
        // Every selector, alternating direction
        for (int s = 0; s < 8; s++) begin
            l = 8'($urandom);
            cmd(`SCO_OP_STREAM, {l, 1'b1, s[0], 3'h0, s[2:0]}, 8'h40);
            slim(s[2:0], exp_lim(l));
        end
        // Nonzero limit passes through unchanged
        s_lim <= 40'h12345;
        slim(3'h5, 40'h12345);
        s_lim <= 40'h0;
        wreg(`SCO_A_INT_STS, 32'h7);
        wreg(`SCO_A_INT_MASK, 32'h1);
        wreg(`SCO_A_COUNT, 32'($urandom) & 32'hffff);
        cmd(`SCO_OP_STREAM, {8'h00, 5'h10, sel}, 8'h40);
        slim(sel, MIN);
        rreg(`SCO_A_INT_STS, 32'h1);
        irq_is(1'b1);
        wreg(`SCO_A_INT_MASK, 32'h0);
        irq_is(1'b0);
        wreg(`SCO_A_INT_MASK, 32'h1);
        wreg(`SCO_A_INT_STS, 32'h1);
        irq_is(1'b0);
        rreg(`SCO_A_INT_STS, 32'h0);
        sup <= 1'b0;
        repeat (4) @(posedge clk);
        cmd(`SCO_OP_STREAM, {8'hff, 5'h10, sel}, 8'h41);
        sup <= 1'b1;
        repeat (4) @(posedge clk);
        slim(sel, MIN);
        cmd(`SCO_OP_STREAM, {8'h00, 5'h00, sel}, 8'h40);
        cmd(`SCO_OP_STREAM, {8'h00, 5'h00, sel}, 8'h41);
        // Overlay family
        cmd(`SCO_OP_OVERLAY, {8'h00, `SCO_DCO_IDENTIFY}, 8'h48);
        cmd(`SCO_OP_OVERLAY, 16'h00c4, 8'h41);
        cmd(`SCO_OP_OVERLAY, 16'h00bf, 8'h41);
        vio <= 1'b1;
        vr <= 8'($urandom);
        vw <= 8'($urandom);
        vb <= 8'($urandom);
        dly <= 4'($urandom);
        cmd(`SCO_OP_OVERLAY, {8'h00, `SCO_DCO_SET}, 8'h41);
        rreg(`SCO_A_COUNT_OUT, {24'h0, vr});
        rreg(`SCO_A_CYL, {16'h0, vw, vb});
        vio <= 1'b0;
        cmd(`SCO_OP_OVERLAY, {8'h00, `SCO_DCO_RESTORE}, 8'h40);
        rreg(`SCO_A_COUNT_OUT, 32'h0);
        rreg(`SCO_A_ELAPSED, 32'h0);
        cmd(`SCO_OP_OVERLAY, {8'h00, `SCO_DCO_FREEZE}, 8'h40);
        for (int k = 0; k < 4; k++) cmd(`SCO_OP_OVERLAY, {8'h00, 8'hc0 + 8'(k)}, 8'h41);
        // Plain reset keeps the lock, power-on clears it
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        cmd(`SCO_OP_OVERLAY, {8'h00, `SCO_DCO_IDENTIFY}, 8'h41);
        por <= 1'b1;
        reset <= 1'b1;
        @(posedge clk);
        por <= 1'b0;
        @(posedge clk);
        reset <= 1'b0;
        cmd(`SCO_OP_OVERLAY, {8'h00, `SCO_DCO_IDENTIFY}, 8'h48);
        repeat (4) @(posedge clk);
        end_of_test();
    end
endmodule

//--- verilog/sco_cmd.sv
// Summary of operation
// RULE1 - Command 51h decodes as stream configuration
// RULE2 - Feature bit 7: add or remove stream
// RULE3 - Add on valid selector overwrites stored parameters
// RULE4 - Aborted configuration leaves stream parameters unchanged
// RULE5 - Abort when streaming is not supported
// RULE6 - Abort removal of never configured selector
// RULE7 - Feature bit 6: read or write stream
// RULE8 - Selector in feature bits 2:0, values 0-7
// RULE9 - Default limit is feature high byte times unit
// RULE10 - Zero limit later applies stored default
// RULE11 - Time counted from command write to completion interrupt
// RULE12 - Limit below minimum is raised to minimum; code raises only the stored default, a nonzero strm_cmd_limit passes unchanged
// RULE13 - Allocation unit: sixteen bits from both count bytes
// RULE14 - Command B1h decodes as overlay family
// RULE15 - Overlay feature selects restore, freeze, identify, set
// RULE16 - Restriction abort returns reason, word, bit
// RULE17 - After freeze lock all overlay commands abort
// RULE18 - Reserved overlay feature codes abort
// RULE19 - Completion reports abort only, no fault, interrupt
`include "sco_map.svh"

module sco_cmd #(
    parameter logic [39:0] MIN_LIMIT_US = 40'h1
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        power_on_reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        streaming_supported,
    output logic             check_req,
    output logic             check_set,
    input  wire logic        check_done,
    input  wire logic        check_violation,
    input  wire logic [7:0]  check_reason,
    input  wire logic [7:0]  check_word,
    input  wire logic [7:0]  check_bit,
    output logic             identify_req,
    input  wire logic        strm_cmd_valid,
    input  wire logic [2:0]  strm_cmd_sel,
    input  wire logic [39:0] strm_cmd_limit,
    output logic      [39:0] strm_limit_us,
    output logic             strm_limit_valid,
    output logic             intrq,
    output logic             irq
);
    // Last prescaler count of one microsecond
    localparam logic [7:0] US_LAST = 8'(`SCO_US_CYCLES - 1);

    // Prescaler must fit its eight bits and minimum must be nonzero
    if (`SCO_US_CYCLES > 256 || MIN_LIMIT_US == 40'h0) begin : g_bad_param
        $error("sco_cmd: unsupported parameter values");
    end

    sco_pkg::sco_state_t r;      // Registered state
    sco_pkg::sco_state_t next_r; // Next state

    // Default limit scaled by the unit, clamped at the minimum
    function automatic logic [39:0] sco_scale(input logic [7:0] lim, input logic [31:0] unit);
        logic [39:0] prod;
        prod = 40'(lim) * 40'(unit); // RULE9
        if (prod < MIN_LIMIT_US) begin
            prod = MIN_LIMIT_US; // RULE12
        end
        return prod;
    endfunction

    // Next state logic
    always_comb begin
        logic [2:0] sel;
        logic       done;
        logic       abort;
        sel   = r.feature[`SCO_FEAT_SEL_HI:0]; // RULE8
        done  = 1'b0;
        abort = 1'b0;
        next_r = r;
        // Single cycle pulses
        next_r.limit_valid  = 1'b0;
        next_r.identify_req = 1'b0;
        next_r.check_req    = 1'b0;
        // Support pin comes from outside the clock domain
        next_r.sup_meta = streaming_supported;
        next_r.sup_sync = r.sup_meta;

        // Microsecond timer runs while a command is busy
        if (r.state != sco_pkg::SCO_IDLE) begin
            if (r.prescale == US_LAST) begin
                next_r.prescale = 8'h0;
                next_r.elapsed  = r.elapsed + 32'h1; // RULE11
            end else begin
                next_r.prescale = r.prescale + 8'h1;
            end
        end

        // Read data valid only in the cycle after the strobe
        next_r.rdata = 32'h0;
        if (reg_rd) begin
            unique case (reg_addr)
                `SCO_A_FEATURE:   next_r.rdata = {16'h0, r.feature};
                `SCO_A_COUNT:     next_r.rdata = {16'h0, r.count};
                `SCO_A_COMMAND:   next_r.rdata = {24'h0, r.command};
                `SCO_A_ERROR:     next_r.rdata = {24'h0, r.error};
                `SCO_A_STATUS:    next_r.rdata = {24'h0, r.status};
                `SCO_A_COUNT_OUT: next_r.rdata = {24'h0, r.count_out};
                `SCO_A_CYL:       next_r.rdata = {16'h0, r.cyl_hi, r.cyl_lo};
                `SCO_A_INT_STS:   next_r.rdata = {29'h0, r.int_sts};
                `SCO_A_INT_MASK:  next_r.rdata = {29'h0, r.int_mask};
                `SCO_A_LIM_UNIT:  next_r.rdata = r.limit_unit;
                `SCO_A_ELAPSED:   next_r.rdata = r.elapsed;
                default:          next_r.rdata = 32'h0; // Unmapped reads zero
            endcase
            // Reading status acknowledges the completion interrupt
            if (reg_addr == `SCO_A_STATUS) begin
                next_r.intrq = 1'b0;
            end
        end

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `SCO_A_FEATURE:   next_r.feature = reg_wdata[15:0];
                `SCO_A_COUNT:     next_r.count = reg_wdata[15:0];
                `SCO_A_COMMAND: begin
                    // Writes while busy are dropped, the host must poll busy
                    if (r.state == sco_pkg::SCO_IDLE) begin
                        next_r.command  = reg_wdata[7:0];
                        next_r.state    = sco_pkg::SCO_EXEC;
                        next_r.status   = `SCO_STS_RESET | 8'h80;
                        next_r.error    = 8'h0;
                        next_r.intrq    = 1'b0;
                        next_r.elapsed  = 32'h0; // RULE11
                        next_r.prescale = 8'h0;
                    end
                end
                `SCO_A_INT_STS:   next_r.int_sts = r.int_sts & ~reg_wdata[2:0];
                `SCO_A_INT_MASK:  next_r.int_mask = reg_wdata[2:0];
                `SCO_A_LIM_UNIT:  next_r.limit_unit = reg_wdata;
                default: begin
                    // Read-only and unmapped writes ignored
                end
            endcase
        end

        // Command sequencer
        unique case (r.state)
            sco_pkg::SCO_IDLE: begin
                // Waiting for a command write
            end
            sco_pkg::SCO_EXEC: begin
                done = 1'b1;
                next_r.count_out = 8'h0;
                next_r.cyl_lo    = 8'h0;
                next_r.cyl_hi    = 8'h0;
                if (r.command == `SCO_OP_STREAM) begin // RULE1
                    if (!r.sup_sync) begin
                        abort = 1'b1; // RULE5
                    end else if (r.feature[`SCO_FEAT_ADD]) begin // RULE2
                        // Add or replace, also when already valid
                        next_r.valid[sel] = 1'b1; // RULE3
                        next_r.dir[sel]   = r.feature[`SCO_FEAT_DIR]; // RULE7
                        next_r.def_limit[sel] = sco_scale(r.feature[`SCO_FEAT_LIM_HI:`SCO_FEAT_LIM_LO],
                                                          r.limit_unit); // RULE9
                        next_r.alloc[sel] = r.count; // RULE13
                    end else if (!r.valid[sel]) begin
                        abort = 1'b1; // RULE6
                    end else begin
                        next_r.valid[sel] = 1'b0; // RULE2
                    end
                    // Aborted paths write nothing to the stream table (RULE4)
                end else if (r.command == `SCO_OP_OVERLAY) begin // RULE14
                    if (r.freeze) begin
                        abort = 1'b1; // RULE17
                    end else begin
                        unique case (r.feature[7:0]) // RULE15
                            `SCO_DCO_RESTORE, `SCO_DCO_SET: begin
                                // Restriction check lives in the checker
                                done = 1'b0;
                                next_r.check_req = 1'b1;
                                next_r.check_set = (r.feature[7:0] == `SCO_DCO_SET);
                                next_r.state     = sco_pkg::SCO_WAIT;
                            end
                            `SCO_DCO_FREEZE: begin
                                next_r.freeze = 1'b1; // RULE17
                                next_r.int_sts[`SCO_INT_FREEZE] = 1'b1;
                            end
                            `SCO_DCO_IDENTIFY: begin
                                // Data phase is handled elsewhere
                                next_r.identify_req = 1'b1;
                            end
                            default: abort = 1'b1; // RULE18
                        endcase
                    end
                end else begin
                    // Opcodes outside this block abort
                    abort = 1'b1;
                end
            end
            sco_pkg::SCO_WAIT: begin
                // Checker verdict for set or restore
                if (check_done) begin
                    done = 1'b1;
                    if (check_violation) begin
                        abort = 1'b1;
                        next_r.count_out = check_reason; // RULE16
                        next_r.cyl_hi    = check_word; // RULE16
                        next_r.cyl_lo    = check_bit; // RULE16
                    end
                end
            end
            default: begin
                // Illegal code recovers to idle
                next_r.state = sco_pkg::SCO_IDLE;
            end
        endcase

        // Completion reporting, event sets after any clear write
        if (done) begin
            next_r.state = sco_pkg::SCO_IDLE;
            next_r.status = `SCO_STS_RESET; // RULE19
            next_r.status[`SCO_STS_ERR] = abort;
            next_r.status[`SCO_STS_DRQ] = next_r.identify_req;
            next_r.error = abort ? 8'h04 : 8'h0; // RULE19
            next_r.intrq = 1'b1; // RULE19
            next_r.int_sts[`SCO_INT_DONE] = 1'b1;
            if (abort) begin
                next_r.int_sts[`SCO_INT_ABORT] = 1'b1;
            end
        end

        // Later streaming command picks its completion limit
        if (strm_cmd_valid) begin
            next_r.limit_valid = 1'b1;
            if (strm_cmd_limit == 40'h0) begin
                next_r.limit = r.def_limit[strm_cmd_sel]; // RULE10
            end else begin
                next_r.limit = strm_cmd_limit;
            end
        end

        // Level interrupt from unmasked sticky bits
        next_r.irq = |(next_r.int_sts & next_r.int_mask);

        // Reset keeps the freeze lock, only power-on clears it
        if (reset) begin
            next_r = '0;
            next_r.status = `SCO_STS_RESET;
            next_r.freeze = r.freeze; // RULE17
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (power_on_reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata        = r.rdata;
    assign check_req        = r.check_req;
    assign check_set        = r.check_set;
    assign identify_req     = r.identify_req;
    assign strm_limit_us    = r.limit;
    assign strm_limit_valid = r.limit_valid;
    assign intrq            = r.intrq;
    assign irq              = r.irq;

    // Checks of the command behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset || power_on_reset);

    a_no_support_abort: assert property ( // RULE5
        r.state == sco_pkg::SCO_EXEC && r.command == `SCO_OP_STREAM && !r.sup_sync
        |=> r.error[`SCO_ERR_ABT] && r.status[`SCO_STS_ERR] && r.intrq)
        else $error("unsupported stream config not aborted");

    a_remove_unknown: assert property ( // RULE6
        r.state == sco_pkg::SCO_EXEC && r.command == `SCO_OP_STREAM && r.sup_sync
        && !r.feature[`SCO_FEAT_ADD] && !r.valid[r.feature[2:0]]
        |=> r.error[`SCO_ERR_ABT] && !r.valid[$past(r.feature[2:0])])
        else $error("removal of unknown stream not aborted");

    a_add_stores: assert property ( // RULE3
        r.state == sco_pkg::SCO_EXEC && r.command == `SCO_OP_STREAM && r.sup_sync
        && r.feature[`SCO_FEAT_ADD]
        |=> r.valid[$past(r.feature[2:0])] && r.alloc[$past(r.feature[2:0])] == $past(r.count)
        && r.def_limit[$past(r.feature[2:0])] >= MIN_LIMIT_US && !r.error[`SCO_ERR_ABT])
        else $error("added stream not stored");

    a_abort_keeps: assert property ( // RULE4
        r.state == sco_pkg::SCO_EXEC && r.command == `SCO_OP_STREAM
        && (!r.sup_sync || (!r.feature[`SCO_FEAT_ADD] && !r.valid[r.feature[2:0]]))
        |=> $stable(r.def_limit) && $stable(r.alloc) && $stable(r.valid))
        else $error("aborted stream config changed the table");

    a_default_limit: assert property ( // RULE10
        strm_cmd_valid && strm_cmd_limit == 40'h0 && r.state == sco_pkg::SCO_IDLE
        |=> strm_limit_valid && strm_limit_us == r.def_limit[$past(strm_cmd_sel)])
        else $error("stored default limit not applied");

    a_freeze_blocks: assert property ( // RULE17
        r.state == sco_pkg::SCO_EXEC && r.command == `SCO_OP_OVERLAY && r.freeze
        |=> r.error[`SCO_ERR_ABT] && !check_req && !identify_req)
        else $error("overlay command accepted after freeze");

    a_reserved_abort: assert property ( // RULE18
        r.state == sco_pkg::SCO_EXEC && r.command == `SCO_OP_OVERLAY && !r.freeze
        && r.feature[7:0] != `SCO_DCO_RESTORE && r.feature[7:0] != `SCO_DCO_FREEZE
        && r.feature[7:0] != `SCO_DCO_IDENTIFY && r.feature[7:0] != `SCO_DCO_SET
        |=> r.error[`SCO_ERR_ABT] && r.status[`SCO_STS_ERR])
        else $error("reserved overlay code not aborted");

    a_violation_codes: assert property ( // RULE16
        r.state == sco_pkg::SCO_WAIT && check_done && check_violation
        |=> r.count_out == $past(check_reason) && r.cyl_hi == $past(check_word)
        && r.cyl_lo == $past(check_bit) && r.error[`SCO_ERR_ABT])
        else $error("violation codes not returned");

    a_done_status: assert property ( // RULE19
        $rose(intrq) |-> !r.status[`SCO_STS_DF] && !r.status[`SCO_STS_BSY]
        && (r.error & 8'hfb) == 8'h0)
        else $error("completion status wrong");

    a_set_handoff: assert property ( // RULE15
        r.state == sco_pkg::SCO_EXEC && r.command == `SCO_OP_OVERLAY && !r.freeze
        && r.feature[7:0] == `SCO_DCO_SET
        |=> check_req && check_set && r.state == sco_pkg::SCO_WAIT)
        else $error("overlay set not handed to checker");
endmodule
